// [src/lmc_mode_ctrl.sv]
`timescale 1ns/1ps
`include "lmc_consts.svh"
module lmc_mode_ctrl
  import lmc_pkg::*;
#(
  parameter int ADDR_W = 13,
  parameter int COL_W  = 10
) (
  input  wire logic                    mclk,
  input  wire logic                    rstn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`LMC_PADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire lmc_cmd_s                cmd,
  output lmc_beat_s                    beat,
  output logic                         rd_first_data,
  output logic      [4:0]              burst_len,
  output logic                         interleave_order,
  output logic      [1:0]              read_latency_cycles,
  output logic      [3:0]              refresh_bank_mask,
  output logic      [1:0]              refresh_row_top_zero,
  output logic      [2:0]              output_strength_select,
  output logic                         self_refresh_active
);
  initial begin
    if (ADDR_W < `LMC_EXT_W + 1 || ADDR_W > `LMC_ADDR_MAX) $error("ADDR_W out of range");
    if (COL_W > ADDR_W) $error("COL_W wider than ADDR_W");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  logic [`LMC_STD_W-1:0] std_word_reg;
  logic [`LMC_EXT_W-1:0] extended_config_word;
  logic                  sref_reg;
  logic                  dpd_pulse;
  logic                  reject_reg;
  logic                  seq_busy;
  logic                  is_load;
  logic                  std_sel;
  logic                  ext_sel;
  logic                  std_ok;
  logic                  ext_ok;
  logic                  seq_start;
  logic [2:0]            ext_partial_refresh_select;
  logic [2:0]            ext_ds;

  assign is_load  = (cmd.op == LMC_CMD_LOAD);
  assign std_sel  = is_load && !cmd.bank_sel_bit1 && !cmd.bank_sel_bit0;
  assign ext_sel  = is_load && cmd.bank_sel_bit1 && !cmd.bank_sel_bit0;
  assign ext_partial_refresh_select = cmd.addr[`LMC_EXT_PARTIAL_REFRESH_SELECT_MSB:`LMC_EXT_PARTIAL_REFRESH_SELECT_LSB];
  assign ext_ds   = cmd.addr[`LMC_EXT_DS_MSB:`LMC_EXT_DS_LSB];

  // Reserved encodings are refused so the burst logic never sees them
  assign std_ok = (cmd.addr[ADDR_W-1:`LMC_STD_W] == '0)
               && (lmc_bl_log2(cmd.addr[`LMC_STD_BL_MSB:`LMC_STD_BL_LSB]) != 3'h0)
               && (lmc_cl_cycles(cmd.addr[`LMC_STD_CL_MSB:`LMC_STD_CL_LSB]) != 2'h0);
  assign ext_ok = (cmd.addr[ADDR_W-1:`LMC_EXT_W] == '0)
               && (ext_partial_refresh_select == `LMC_PARTIAL_REFRESH_SELECT_FULL || ext_partial_refresh_select == `LMC_PARTIAL_REFRESH_SELECT_HALF
                   || ext_partial_refresh_select == `LMC_PARTIAL_REFRESH_SELECT_QUARTER || ext_partial_refresh_select == `LMC_PARTIAL_REFRESH_SELECT_EIGHTH
                   || ext_partial_refresh_select == `LMC_PARTIAL_REFRESH_SELECT_SIXTEENTH)
               && (ext_ds == `LMC_DS_FULL || ext_ds == `LMC_DS_HALF || ext_ds == `LMC_DS_THREEQ);

  assign seq_start = (cmd.op == LMC_CMD_READ) || (cmd.op == LMC_CMD_WRITE);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration words

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      std_word_reg <= `LMC_STD_RESET;
    end else if (dpd_pulse) begin
      std_word_reg <= `LMC_STD_RESET;
    end else if (std_sel && std_ok) begin
      std_word_reg <= cmd.addr[`LMC_STD_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      extended_config_word <= `LMC_EXT_RESET;
    end else if (dpd_pulse) begin
      extended_config_word <= `LMC_EXT_RESET;
    end else if (ext_sel && ext_ok) begin
      extended_config_word <= cmd.addr[`LMC_EXT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded settings, one register stage behind the words

  logic [2:0] partial_refresh_select_cur;
  logic [2:0] std_lg;
  logic [1:0] std_cl;

  assign partial_refresh_select_cur = extended_config_word[`LMC_EXT_PARTIAL_REFRESH_SELECT_MSB:`LMC_EXT_PARTIAL_REFRESH_SELECT_LSB];
  assign std_lg   = lmc_bl_log2(std_word_reg[`LMC_STD_BL_MSB:`LMC_STD_BL_LSB]);
  assign std_cl   = lmc_cl_cycles(std_word_reg[`LMC_STD_CL_MSB:`LMC_STD_CL_LSB]);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      burst_len           <= 5'h04;
      interleave_order    <= 1'b0;
      read_latency_cycles <= 2'h3;
    end else begin
      burst_len           <= 5'(6'h01 << std_lg);
      interleave_order    <= std_word_reg[`LMC_STD_TYPE_BIT];
      read_latency_cycles <= std_cl;
    end
  end

  // Temperature compensation bits are stored but drive nothing
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      refresh_bank_mask      <= `LMC_BANKS_ALL;
      refresh_row_top_zero   <= 2'h0;
      output_strength_select <= `LMC_DS_FULL;
      self_refresh_active    <= 1'b0;
    end else begin
      output_strength_select <= extended_config_word[`LMC_EXT_DS_MSB:`LMC_EXT_DS_LSB];
      self_refresh_active    <= sref_reg;
      if (!sref_reg) begin
        refresh_bank_mask    <= `LMC_BANKS_ALL;
        refresh_row_top_zero <= 2'h0;
      end else begin
        case (partial_refresh_select_cur)
          `LMC_PARTIAL_REFRESH_SELECT_HALF: begin
            refresh_bank_mask    <= `LMC_BANKS_HALF;
            refresh_row_top_zero <= 2'h0;
          end
          `LMC_PARTIAL_REFRESH_SELECT_QUARTER: begin
            refresh_bank_mask    <= `LMC_BANKS_QUARTER;
            refresh_row_top_zero <= 2'h0;
          end
          `LMC_PARTIAL_REFRESH_SELECT_EIGHTH: begin
            refresh_bank_mask    <= `LMC_BANKS_QUARTER;
            refresh_row_top_zero <= 2'h1;
          end
          `LMC_PARTIAL_REFRESH_SELECT_SIXTEENTH: begin
            refresh_bank_mask    <= `LMC_BANKS_QUARTER;
            refresh_row_top_zero <= 2'h2;
          end
          default: begin
            refresh_bank_mask    <= `LMC_BANKS_ALL;
            refresh_row_top_zero <= 2'h0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst sequencing and read latency

  // Same length for reads and writes; a new read or write truncates the running burst
  lmc_burst_seq #(
    .COL_W (COL_W)
  ) u_seq (
    .mclk       (mclk),
    .rstn       (rstn),
    .start      (seq_start),
    .start_read (cmd.op == LMC_CMD_READ),
    .start_col  (cmd.addr[COL_W-1:0]),
    .len_log2   (std_lg),
    .interleave (std_word_reg[`LMC_STD_TYPE_BIT]),
    .beat_reg   (beat),
    .busy       (seq_busy)
  );

  lmc_read_lat #(
    .MAX_LAT (3)
  ) u_lat (
    .mclk           (mclk),
    .rstn           (rstn),
    .rd_cmd         (cmd.op == LMC_CMD_READ),
    .lat            (std_cl),
    .first_data_reg (rd_first_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  logic apb_access;
  logic apb_done;
  logic wr_ctrl;
  logic wr_status;

  function automatic logic apb_mapped(input logic [`LMC_PADDR_W-1:0] a);
    return (a == `LMC_OFS_MODE_VIEW) || (a == `LMC_OFS_EXT_VIEW)
        || (a == `LMC_OFS_CTRL) || (a == `LMC_OFS_STATUS);
  endfunction

  assign apb_access = psel && penable && !pready;
  assign apb_done   = psel && penable && pready;
  assign wr_ctrl    = apb_done && pwrite && (paddr == `LMC_OFS_CTRL);
  assign wr_status  = apb_done && pwrite && (paddr == `LMC_OFS_STATUS);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_access;
      pslverr <= apb_access && !apb_mapped(paddr);
      prdata  <= 32'h0000_0000;
      if (apb_access && !pwrite) begin
        case (paddr)
          `LMC_OFS_MODE_VIEW: prdata <= 32'(std_word_reg);
          `LMC_OFS_EXT_VIEW:  prdata <= 32'(extended_config_word);
          `LMC_OFS_CTRL:      prdata <= 32'({1'b0, sref_reg});
          `LMC_OFS_STATUS:    prdata <= 32'({reject_reg, seq_busy});
          default:            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Power-down request is a one-cycle pulse; self refresh is a level
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sref_reg  <= 1'b0;
      dpd_pulse <= 1'b0;
    end else begin
      dpd_pulse <= wr_ctrl && pwdata[`LMC_CTRL_DPD_BIT];
      if (wr_ctrl) begin
        sref_reg <= pwdata[`LMC_CTRL_SREF_BIT];
      end
    end
  end

  // Sticky reserved-load flag, write one to clear, a new refusal wins
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reject_reg <= 1'b0;
    end else begin
      reject_reg <= ((std_sel && !std_ok) || (ext_sel && !ext_ok))
                 || (reject_reg && !(wr_status && pwdata[`LMC_STAT_REJ_BIT]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [3:0]              chk_k_reg;
  logic [`LMC_ADDR_MAX-1:0] chk_first_reg;
  logic                    chk_first_beat;
  logic [`LMC_ADDR_MAX-1:0] chk_mask;
  logic [4:0]              chk_len_reg;
  logic                    chk_il_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      chk_first_beat <= 1'b0;
      chk_len_reg    <= 5'h00;
      chk_il_reg     <= 1'b0;
    end else begin
      chk_first_beat <= seq_start;
      if (seq_start) begin
        chk_len_reg <= 5'(6'h01 << std_lg);
        chk_il_reg  <= std_word_reg[`LMC_STD_TYPE_BIT];
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      chk_k_reg     <= 4'h0;
      chk_first_reg <= '0;
    end else if (beat.valid && chk_first_beat) begin
      chk_k_reg     <= 4'h1;
      chk_first_reg <= beat.col;
    end else if (beat.valid) begin
      chk_k_reg     <= chk_k_reg + 4'h1;
    end
  end

  assign chk_mask = `LMC_ADDR_MAX'(chk_len_reg) - `LMC_ADDR_MAX'(1);

  property p_len_legal;
    @(posedge mclk) disable iff (!rstn)
    burst_len == 5'h02 || burst_len == 5'h04 || burst_len == 5'h08 || burst_len == 5'h10;
  endproperty
  a_len_legal: assert property (p_len_legal) else $error("illegal burst length");

  property p_last_count;
    @(posedge mclk) disable iff (!rstn)
    (beat.valid && beat.last && !chk_first_beat) |-> (5'(chk_k_reg) == chk_len_reg - 5'h01);
  endproperty
  a_last_count: assert property (p_last_count) else $error("burst beat count wrong");

  property p_block_fixed;
    @(posedge mclk) disable iff (!rstn)
    (beat.valid && !chk_first_beat) |-> ((beat.col & ~chk_mask) == (chk_first_reg & ~chk_mask));
  endproperty
  a_block_fixed: assert property (p_block_fixed) else $error("burst left its block");

  property p_seq_order;
    @(posedge mclk) disable iff (!rstn)
    (beat.valid && !chk_first_beat && !chk_il_reg)
      |-> ((beat.col & chk_mask) == ((chk_first_reg + `LMC_ADDR_MAX'(chk_k_reg)) & chk_mask));
  endproperty
  a_seq_order: assert property (p_seq_order) else $error("sequential order wrong");

  property p_il_order;
    @(posedge mclk) disable iff (!rstn)
    (beat.valid && !chk_first_beat && chk_il_reg)
      |-> ((beat.col & chk_mask) == ((chk_first_reg ^ `LMC_ADDR_MAX'(chk_k_reg)) & chk_mask));
  endproperty
  a_il_order: assert property (p_il_order) else $error("interleaved order wrong");

  property p_lat_two;
    @(posedge mclk) disable iff (!rstn)
    (cmd.op == LMC_CMD_READ && std_cl == 2'h2) |-> ##2 rd_first_data;
  endproperty
  a_lat_two: assert property (p_lat_two) else $error("latency two missed");

  property p_std_load;
    @(posedge mclk) disable iff (!rstn)
    (std_sel && std_ok && !dpd_pulse) |=> (std_word_reg == $past(cmd.addr[`LMC_STD_W-1:0]));
  endproperty
  a_std_load: assert property (p_std_load) else $error("standard load lost");

  property p_ext_load;
    @(posedge mclk) disable iff (!rstn)
    (ext_sel && ext_ok && !dpd_pulse) |=> (extended_config_word == $past(cmd.addr[`LMC_EXT_W-1:0]));
  endproperty
  a_ext_load: assert property (p_ext_load) else $error("extended load lost");

  property p_ext_hold;
    @(posedge mclk) disable iff (!rstn)
    (!ext_sel && !dpd_pulse) |=> $stable(extended_config_word);
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("extended word changed unasked");

  property p_reserved_refused;
    @(posedge mclk) disable iff (!rstn)
    (std_sel && !std_ok && !dpd_pulse) |=> (reject_reg && $stable(std_word_reg));
  endproperty
  a_reserved_refused: assert property (p_reserved_refused) else $error("reserved load taken");

  property p_partial_refresh_select_quarter;
    @(posedge mclk) disable iff (!rstn)
    (sref_reg && partial_refresh_select_cur == `LMC_PARTIAL_REFRESH_SELECT_QUARTER) |=> (refresh_bank_mask == `LMC_BANKS_QUARTER);
  endproperty
  a_partial_refresh_select_quarter: assert property (p_partial_refresh_select_quarter) else $error("quarter region wrong");

  property p_full_outside_sref;
    @(posedge mclk) disable iff (!rstn)
    !sref_reg |=> (refresh_bank_mask == `LMC_BANKS_ALL && refresh_row_top_zero == 2'h0);
  endproperty
  a_full_outside_sref: assert property (p_full_outside_sref) else $error("region outside refresh");

  property p_strength;
    @(posedge mclk) disable iff (!rstn)
    1'b1 |=> (output_strength_select == $past(extended_config_word[`LMC_EXT_DS_MSB:`LMC_EXT_DS_LSB]));
  endproperty
  a_strength: assert property (p_strength) else $error("drive strength not followed");
endmodule

// [common/lmc_consts.svh]
`ifndef LMC_CONSTS_SVH
`define LMC_CONSTS_SVH
// Register byte offsets
`define LMC_PADDR_W         12
`define LMC_OFS_MODE_VIEW   12'h000
`define LMC_OFS_EXT_VIEW    12'h004
`define LMC_OFS_CTRL        12'h008
`define LMC_OFS_STATUS      12'h00C
`define LMC_CTRL_SREF_BIT   0
`define LMC_CTRL_DPD_BIT    1
`define LMC_STAT_BUSY_BIT   0
`define LMC_STAT_REJ_BIT    1
// Command word layout
`define LMC_ADDR_MAX        16
`define LMC_STD_W           7
`define LMC_STD_BL_MSB      2
`define LMC_STD_BL_LSB      0
`define LMC_STD_TYPE_BIT    3
`define LMC_STD_CL_MSB      6
`define LMC_STD_CL_LSB      4
`define LMC_EXT_W           8
`define LMC_EXT_PARTIAL_REFRESH_SELECT_MSB    2
`define LMC_EXT_PARTIAL_REFRESH_SELECT_LSB    0
`define LMC_EXT_TEMP_COMP_REFRESH_SETTING_MSB    4
`define LMC_EXT_TEMP_COMP_REFRESH_SETTING_LSB    3
`define LMC_EXT_DS_MSB      7
`define LMC_EXT_DS_LSB      5
// Field encodings
`define LMC_BL_2            3'h1
`define LMC_BL_4            3'h2
`define LMC_BL_8            3'h3
`define LMC_BL_16           3'h4
`define LMC_CL_2            3'h2
`define LMC_CL_3            3'h3
`define LMC_PARTIAL_REFRESH_SELECT_FULL       3'h0
`define LMC_PARTIAL_REFRESH_SELECT_HALF       3'h1
`define LMC_PARTIAL_REFRESH_SELECT_QUARTER    3'h2
`define LMC_PARTIAL_REFRESH_SELECT_EIGHTH     3'h5
`define LMC_PARTIAL_REFRESH_SELECT_SIXTEENTH  3'h6
`define LMC_DS_FULL         3'h0
`define LMC_DS_HALF         3'h1
`define LMC_DS_THREEQ       3'h4
`define LMC_BANKS_ALL       4'hF
`define LMC_BANKS_HALF      4'h3
`define LMC_BANKS_QUARTER   4'h1
// Reset values: burst of 4, sequential, latency 3
`define LMC_STD_RESET       7'h32
`define LMC_EXT_RESET       8'h00
`endif

// [common/lmc_pkg.sv]
package lmc_pkg;
`include "lmc_consts.svh"

  typedef enum logic [1:0] {
    LMC_CMD_NOP   = 2'h0,
    LMC_CMD_LOAD  = 2'h1,
    LMC_CMD_READ  = 2'h2,
    LMC_CMD_WRITE = 2'h3
  } lmc_cmd_e;

  typedef struct packed {
    lmc_cmd_e                 op;
    logic                     bank_sel_bit1;
    logic                     bank_sel_bit0;
    logic [`LMC_ADDR_MAX-1:0] addr;
  } lmc_cmd_s;

  typedef struct packed {
    logic                     valid;
    logic                     is_read;
    logic                     last;
    logic [`LMC_ADDR_MAX-1:0] col;
  } lmc_beat_s;

  typedef enum logic [1:0] {
    LMC_SEQ_IDLE = 2'b01,
    LMC_SEQ_RUN  = 2'b10
  } lmc_seq_e;

  // Burst length code to log2 of the length, zero when reserved
  function automatic logic [2:0] lmc_bl_log2(input logic [2:0] code);
    case (code)
      `LMC_BL_2:  lmc_bl_log2 = 3'h1;
      `LMC_BL_4:  lmc_bl_log2 = 3'h2;
      `LMC_BL_8:  lmc_bl_log2 = 3'h3;
      `LMC_BL_16: lmc_bl_log2 = 3'h4;
      default:    lmc_bl_log2 = 3'h0;
    endcase
  endfunction

  // Latency code to cycles, zero when reserved
  function automatic logic [1:0] lmc_cl_cycles(input logic [2:0] code);
    case (code)
      `LMC_CL_2: lmc_cl_cycles = 2'h2;
      `LMC_CL_3: lmc_cl_cycles = 2'h3;
      default:   lmc_cl_cycles = 2'h0;
    endcase
  endfunction
endpackage

// [src/lmc_burst_seq.sv]
`timescale 1ns/1ps
module lmc_burst_seq
  import lmc_pkg::*;
#(
  parameter int COL_W = 10
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             start,
  input  wire logic             start_read,
  input  wire logic [COL_W-1:0] start_col,
  input  wire logic [2:0]       len_log2,
  input  wire logic             interleave,
  output lmc_beat_s             beat_reg,
  output logic                  busy
);
  initial begin
    if (COL_W < 4 || COL_W > `LMC_ADDR_MAX) $error("COL_W out of range");
  end

  lmc_seq_e         state_reg;
  logic [COL_W-1:0] base_reg;
  logic [2:0]       lg_reg;
  logic             il_reg;
  logic             rd_reg;
  logic [3:0]       k_reg;
  logic [3:0]       k_last;

  // Wrap inside the aligned block; low bits walk by add or by xor
  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] base, input logic [3:0] k,
                                                 input logic [2:0] lg, input logic il);
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] low;
    mask = ~({COL_W{1'b1}} << lg);
    low  = il ? (base ^ COL_W'(k)) : (base + COL_W'(k));
    return (base & ~mask) | (low & mask);
  endfunction

  assign k_last = 4'((5'h01 << lg_reg) - 5'h01);
  assign busy   = (state_reg == LMC_SEQ_RUN);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= LMC_SEQ_IDLE;
      base_reg  <= '0;
      lg_reg    <= 3'h0;
      il_reg    <= 1'b0;
      rd_reg    <= 1'b0;
      k_reg     <= 4'h0;
      beat_reg  <= '0;
    end else if (start) begin
      base_reg  <= start_col;
      lg_reg    <= len_log2;
      il_reg    <= interleave;
      rd_reg    <= start_read;
      k_reg     <= 4'h1;
      state_reg <= LMC_SEQ_RUN;
      beat_reg  <= '{valid: 1'b1, is_read: start_read, last: 1'b0, col: `LMC_ADDR_MAX'(start_col)};
    end else begin
      case (state_reg)
        LMC_SEQ_RUN: begin
          beat_reg <= '{valid: 1'b1, is_read: rd_reg, last: (k_reg == k_last),
                        col: `LMC_ADDR_MAX'(burst_col(base_reg, k_reg, lg_reg, il_reg))};
          k_reg    <= k_reg + 4'h1;
          if (k_reg == k_last) begin
            state_reg <= LMC_SEQ_IDLE;
          end
        end
        LMC_SEQ_IDLE: begin
          beat_reg <= '0;
        end
        default: begin
          state_reg <= LMC_SEQ_IDLE;
          beat_reg  <= '0;
        end
      endcase
    end
  end
endmodule

// [src/lmc_read_lat.sv]
`timescale 1ns/1ps
module lmc_read_lat
  import lmc_pkg::*;
#(
  parameter int MAX_LAT = 3
) (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       rd_cmd,
  input  wire logic [1:0] lat,
  output logic            first_data_reg
);
  initial begin
    if (MAX_LAT != 3) $error("MAX_LAT must be 3");
  end

  logic [MAX_LAT-2:0] pipe_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pipe_reg       <= '0;
      first_data_reg <= 1'b0;
    end else begin
      pipe_reg       <= {pipe_reg[MAX_LAT-3:0], rd_cmd};
      first_data_reg <= (lat == 2'h3) ? pipe_reg[1] : pipe_reg[0];
    end
  end

  property p_lat_three;
    @(posedge mclk) disable iff (!rstn)
    (rd_cmd && lat == 2'h3) |-> ##3 first_data_reg;
  endproperty
  a_lat_three: assert property (p_lat_three) else $error("latency three missed");
endmodule

// [tb/lmc_ctrl_model.sv]
`timescale 1ns/1ps
module lmc_ctrl_model
  import lmc_pkg::*;
(
  input  wire logic mclk,
  output lmc_cmd_s  cmd
);
  initial cmd = '0;

  // One command for one cycle; bank bits 00 standard, 10 extended
  task automatic issue(input lmc_cmd_e op, input logic [1:0] bank, input logic [15:0] a);
    @(posedge mclk);
    cmd <= {op, bank, a};
    @(posedge mclk);
    cmd <= '0;
    if (op == LMC_CMD_LOAD) begin
      repeat (2) @(posedge mclk);
    end
  endtask
endmodule

// [tb/lpddr_mode_config_burst_order_bench.sv]
`timescale 1ns/1ps
module lpddr_mode_config_burst_order_bench
  import lmc_pkg::*;
;
  logic            mclk = 0;
  logic            rstn = 0;
  logic            psel = 0;
  logic            penable = 0;
  logic            pwrite = 0;
  logic [11:0]     paddr = '0;
  logic [31:0]     pwdata = '0;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  lmc_cmd_s        cmd;
  lmc_beat_s       beat;
  logic            rd_first_data;
  logic [4:0]      burst_len;
  logic            interleave_order;
  logic [1:0]      read_latency_cycles;
  logic [3:0]      refresh_bank_mask;
  logic [1:0]      refresh_row_top_zero;
  logic [2:0]      output_strength_select;
  logic            self_refresh_active;
  logic [31:0]     r;
  logic            e;
  logic [7:0]      w;
  int              error_cnt = 0;
  int              checks = 0;
  logic [4:0][2:0] ps = {3'h6, 3'h5, 3'h2, 3'h1, 3'h0};
  logic [4:0][2:0] ds = {3'h1, 3'h0, 3'h4, 3'h1, 3'h0};
  logic [4:0][5:0] rm = {6'h21, 6'h11, 6'h01, 6'h03, 6'h0F};

  always #4 mclk = ~mclk;

  lmc_ctrl_model u_ctl (.mclk(mclk), .cmd(cmd));

  lmc_mode_ctrl i_dut (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd(cmd), .beat(beat),
    .rd_first_data(rd_first_data), .burst_len(burst_len), .interleave_order(interleave_order),
    .read_latency_cycles(read_latency_cycles), .refresh_bank_mask(refresh_bank_mask),
    .refresh_row_top_zero(refresh_row_top_zero), .output_strength_select(output_strength_select),
    .self_refresh_active(self_refresh_active)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Answer sampled at the edge where pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge mclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    @(posedge mclk iff pready === 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic burst(input int c, input int t);
    int          n;
    int          cl;
    logic        rd;
    logic [15:0] a;
    logic [15:0] m;
    logic [15:0] lo;
    n = 1 << c;
    cl = 2 + t;
    rd = c[0] ^ t[0];
    a = 16'h0135 + 16'(3 * c);
    m = 16'(n - 1);
    u_ctl.issue(LMC_CMD_LOAD, 2'h0, 16'({cl[2:0], t[0], c[2:0]}));
    chk(burst_len, n);
    chk(interleave_order, t);
    chk(read_latency_cycles, cl);
    u_ctl.issue(rd ? LMC_CMD_READ : LMC_CMD_WRITE, 2'h0, a);
    for (int k = 0; k < n + 2; k++) begin
      @(negedge mclk);
      lo = t ? (a ^ 16'(k)) : (a + 16'(k));
      if (k < n) chk(beat, {1'b1, rd, k == n - 1, a & ~m | lo & m});
      else chk(beat.valid, 0);
      chk(rd_first_data, rd && k + 1 == cl);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1;
    chk(burst_len, 4);
    chk(read_latency_cycles, 3);
    apb(0, 12'h000, 0, r, e);
    chk(r, 32'h32);
    for (int c = 1; c <= 4; c++)
      for (int t = 0; t < 2; t++)
        burst(c, t);
    apb(1, 12'h008, 1, r, e);
    for (int i = 0; i < 5; i++) begin
      w = {ds[i], 2'(i), ps[i]};
      u_ctl.issue(LMC_CMD_LOAD, 2'h2, {8'h0, w});
      chk({refresh_row_top_zero, refresh_bank_mask}, rm[i]);
      chk(output_strength_select, ds[i]);
      chk(self_refresh_active, 1);
      apb(0, 12'h004, 0, r, e);
      chk(r, w);
    end
    u_ctl.issue(LMC_CMD_LOAD, 2'h0, 16'h00A2);
    apb(0, 12'h000, 0, r, e);
    chk(r, 32'h3C);
    apb(0, 12'h00C, 0, r, e);
    chk(r, 32'h2);
    apb(0, 12'h010, 0, r, e);
    chk({e, r[30:0]}, 32'h80000000);
    apb(1, 12'h008, 2, r, e);
    apb(0, 12'h000, 0, r, e);
    chk(r, 32'h32);
    apb(0, 12'h004, 0, r, e);
    chk(r, 0);
    chk(refresh_bank_mask, 4'hF);
    apb(1, 12'h00C, 32'h2, r, e);
    apb(0, 12'h00C, 0, r, e);
    chk(r, 32'h0);
    u_ctl.issue(LMC_CMD_WRITE, 2'h0, 16'h0004);
    apb(0, 12'h00C, 0, r, e);
    chk(r, 32'h1);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    test_done();
  end
endmodule
